/* pkg/ptw_if.sv */
/*
 Interface joining the CPU-side controller to the timer block.
 Assumes both ends share clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
interface ptw_if;
   import ptw_pkg::*;
   ptw_op_type op;
   logic [1:0] sel;
   logic [PTW_DATA_W-1:0] wdata;
   logic [PTW_CTL_W-1:0] ctl;
   logic [PTW_DATA_W-1:0] rdata;
   logic skip;
   logic [2:0] uflow;
   logic wdt_flag;
   logic wdt_enable;
   logic pwm;
   modport dev (input op, input sel, input wdata, input ctl, output rdata, output skip,
      output uflow, output wdt_flag, output wdt_enable, output pwm);
   modport ctl_end (output op, output sel, output wdata, output ctl, input rdata, input skip,
      input uflow, input wdt_flag, input wdt_enable, input pwm);
endinterface : ptw_if
`default_nettype wire

/* pkg/ptw_pkg.sv */
/*
 Package for the prescaler, three timers, PWM and watchdog block and its CPU-side controller.
 Assumes a single system clock and a synchronous active-low reset.
*/
// Behaviour
// - Software halts prescaler before reading it
// - Software halts prescaler before writing it
// - Timer stopped before count source change
// - Timer count read only when stopped
// - Timer count load only when stopped
// - Timer 1 reload write avoids underflow cycle
// - Timer 3 high reload write avoids underflow
// - Stop on timer 3 underflow may glitch PWM
// - High reload at least one for expansion
// - Port C latch zero to output PWM
// - Counting begins at first source rising edge
// - First underflow may come one period early
// - Pin source counts on selected edge polarity
// - Watchdog on after reset; disable then restart
// - Back-up entry clears watchdog flag and counter
// - Restart clears overflow flag before back-up
// - Prescaler source bit zero selects instruction clock
// - Irq enable zero makes skip valid
package ptw_pkg;
   typedef enum logic [3:0] {
      PTW_OP_NONE, PTW_OP_READ_PRESCALER, PTW_OP_WRITE_PRESCALER, PTW_OP_READ_TIMER,
      PTW_OP_WRITE_TIMER, PTW_OP_LOAD_THIRD_BOTH, PTW_OP_WRITE_RELOAD, PTW_OP_WRITE_THIRD_HIGH,
      PTW_OP_WRITE_CONTROL, PTW_OP_DISABLE_WATCHDOG, PTW_OP_WATCHDOG_RESTART, PTW_OP_BACKUP_ENTRY,
      PTW_OP_SKIP_FIRST
   } ptw_op_type;
   localparam int PTW_DATA_W = 8;
   localparam int PTW_WDT_W = 16;
   // Control word fields
   localparam int PTW_CTL_PRESC_RUN = 0;
   localparam int PTW_CTL_PRESC_SRC = 1;
   localparam int PTW_CTL_T1_RUN = 2;
   localparam int PTW_CTL_T2_RUN = 3;
   localparam int PTW_CTL_T3_RUN = 4;
   localparam int PTW_CTL_T1_PIN = 5;
   localparam int PTW_CTL_T1_EDGE = 6;
   localparam int PTW_CTL_PWM_EN = 7;
   localparam int PTW_CTL_IRQ_EN = 8;
   localparam int PTW_CTL_W = 9;
   localparam logic [PTW_CTL_W-1:0] PTW_CTL_RESET = 9'h000;
   localparam logic [PTW_WDT_W-1:0] PTW_WDT_RESET = 16'hFFFF;
   localparam logic [7:0] PTW_INSTRUCTION_CLOCK_DIV = 8'h03;
   // AXI4-Lite offsets of the controller
   localparam logic [7:0] PTW_ADDR_CMD = 8'h00;
   localparam logic [7:0] PTW_ADDR_ARG = 8'h04;
   localparam logic [7:0] PTW_ADDR_RESULT = 8'h08;
   localparam logic [7:0] PTW_ADDR_STATUS = 8'h0C;
endpackage : ptw_pkg

/* testbench/ptw_checker.sv */
/*
 Assertions on the link between the controller and the timer block.
 Assumes it sits beside the interface, clocked by clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module ptw_checker (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire ptw_pkg::ptw_op_type op,
   input wire logic [ptw_pkg::PTW_CTL_W-1:0] ctl,
   input wire logic [ptw_pkg::PTW_DATA_W-1:0] rdata,
   input wire logic skip,
   input wire logic [2:0] uflow,
   input wire logic wdt_flag,
   input wire logic wdt_enable
);
   import ptw_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // Remembers that the last op issued was a watchdog disable
   logic dis_seen_reg;
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         dis_seen_reg <= 1'b0;
      end else if (op != PTW_OP_NONE) begin
         dis_seen_reg <= (op == PTW_OP_DISABLE_WATCHDOG);
      end
   end
   sequence s_disable_then_restart;
      dis_seen_reg && op == PTW_OP_WATCHDOG_RESTART;
   endsequence
   sequence s_skip_issued;
      $past(op) == PTW_OP_SKIP_FIRST || $past(op, 2) == PTW_OP_SKIP_FIRST;
   endsequence
   property p_wdt_on_release;
      $rose(rst_b) |-> wdt_enable;
   endproperty
   property p_wdt_disable;
      s_disable_then_restart |-> ##[1:2] !wdt_enable;
   endproperty
   property p_wdt_no_reenable;
      !$rose(wdt_enable);
   endproperty
   property p_backup_clears;
      op == PTW_OP_BACKUP_ENTRY |-> ##[1:2] !wdt_flag;
   endproperty
   property p_restart_clears;
      op == PTW_OP_WATCHDOG_RESTART |-> ##[1:2] !wdt_flag;
   endproperty
   property p_skip_cause;
      $rose(skip) |-> s_skip_issued and !ctl[PTW_CTL_IRQ_EN];
   endproperty
   property p_skip_pulse;
      skip |=> !skip;
   endproperty
   property p_rdata_cause;
      $changed(rdata) |-> $past(op) inside {PTW_OP_READ_PRESCALER, PTW_OP_READ_TIMER}
         || $past(op, 2) inside {PTW_OP_READ_PRESCALER, PTW_OP_READ_TIMER};
   endproperty
   property p_uflow_needs_run;
      $rose(uflow[1]) |-> $past(ctl[PTW_CTL_T2_RUN]) || $past(ctl[PTW_CTL_T2_RUN], 2);
   endproperty
   property p_wdt_flag_enabled;
      $rose(wdt_flag) |-> $past(wdt_enable);
   endproperty
   a_wdt_on_release: assert property (p_wdt_on_release) else $error("watchdog off after reset");
   a_wdt_disable: assert property (p_wdt_disable) else $error("watchdog not disabled");
   a_wdt_no_reenable: assert property (p_wdt_no_reenable) else $error("watchdog enabled again");
   a_backup_clears: assert property (p_backup_clears) else $error("overflow flag kept on backup");
   a_restart_clears: assert property (p_restart_clears) else $error("overflow flag kept on restart");
   a_skip_cause: assert property (p_skip_cause) else $error("skip without skip op");
   a_skip_pulse: assert property (p_skip_pulse) else $error("skip longer than one cycle");
   a_rdata_cause: assert property (p_rdata_cause) else $error("read data changed without read");
   a_uflow_needs_run: assert property (p_uflow_needs_run) else $error("timer 2 flag while stopped");
   a_wdt_flag_enabled: assert property (p_wdt_flag_enabled) else $error("overflow while disabled");
endmodule : ptw_checker
`default_nettype wire

/* testbench/tb_top.sv */
/*
 Self-checking bench: AXI4-Lite master driving the controller, which faces the timer block.
 Assumes the controller register map and op encoding of the package.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import ptw_pkg::*;
   typedef struct {logic [1:0] resp; logic [31:0] data; logic [31:0] mask;} ptw_exp_type;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic counter_pin_zero = 1'b0;
   logic port_c_latch = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, counter_pin_one, system_reset_req;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] cur_ctl = 8'h00;
   logic [7:0] val;
   int cnt;
   int failures = 0, compares = 0, seed = 81223;
   ptw_exp_type rq[$], wq[$], mon_x;
   always #5 clk_sys = ~clk_sys;
   ptw_if ifc();
   ptw_device i_ptw_device (.clk_sys(clk_sys), .rst_b(rst_b), .bus(ifc), .counter_pin_zero(counter_pin_zero),
      .port_c_latch(port_c_latch), .counter_pin_one(counter_pin_one), .system_reset_req(system_reset_req));
   ptw_controller i_ptw_controller (.clk_sys(clk_sys), .rst_b(rst_b), .bus(ifc), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   ptw_checker i_ptw_checker (.clk_sys(clk_sys), .rst_b(rst_b), .op(ifc.op), .ctl(ifc.ctl), .rdata(ifc.rdata),
      .skip(ifc.skip), .uflow(ifc.uflow), .wdt_flag(ifc.wdt_flag), .wdt_enable(ifc.wdt_enable));
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
      compares++;
      if ((g & m) !== (e & m)) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, e & m, g & m);
      end
   endtask : chk
   task automatic end_sim;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   // Results are taken at the negative edge, where every output has settled
   always @(negedge clk_sys) begin
      if (rst_b) begin
         chk("pwm pin", {31'h0, ifc.pwm & ~port_c_latch}, {31'h0, counter_pin_one}, 32'h1);
         chk("reset request", 32'h0, {31'h0, system_reset_req}, 32'h1);
         if (bvalid && bready) begin
            mon_x = wq.pop_front();
            chk("bresp", {30'h0, mon_x.resp}, {30'h0, bresp}, 32'h3);
         end
         if (rvalid && rready) begin
            mon_x = rq.pop_front();
            chk("rresp", {30'h0, mon_x.resp}, {30'h0, rresp}, 32'h3);
            chk("rdata", mon_x.data, rdata, mon_x.mask);
         end
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ok;
      wq.push_back('{r, 32'h0, 32'h0});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin @(negedge clk_sys); ok = awready && wready; @(posedge clk_sys); end while (!ok);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do begin @(negedge clk_sys); ok = bvalid; @(posedge clk_sys); end while (!ok);
      bready <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
      logic ok;
      rq.push_back('{r, e, m});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin @(negedge clk_sys); ok = arready; @(posedge clk_sys); end while (!ok);
      arvalid <= 1'b0;
      do begin @(negedge clk_sys); ok = rvalid; @(posedge clk_sys); end while (!ok);
      rready <= 1'b0;
      @(posedge clk_sys);
   endtask : rd
   task automatic op(input ptw_op_type o);
      wr(PTW_ADDR_CMD, 32'(o), 2'b00);
   endtask : op
   task automatic arg(input logic [1:0] s, input logic [7:0] d);
      wr(PTW_ADDR_ARG, {cur_ctl, 6'h00, s, 8'h00, d}, 2'b00);
   endtask : arg
   task automatic setctl(input logic [7:0] c);
      cur_ctl = c;
      arg(2'd0, 8'h00);
      op(PTW_OP_WRITE_CONTROL);
   endtask : setctl
   task automatic stat(input logic [31:0] e, input logic [31:0] m);
      rd(PTW_ADDR_STATUS, e, m, 2'b00);
   endtask : stat
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      stat(32'h40, 32'h60);
      rd(8'h10, 32'h0, 32'hFFFFFFFF, 2'b10);
      wr(8'h14, 32'h0, 2'b10);
      for (int i = 0; i < 70000 && ifc.wdt_flag !== 1'b1; i++) @(posedge clk_sys);
      stat(32'h60, 32'h60);
      op(PTW_OP_WATCHDOG_RESTART);
      stat(32'h40, 32'h60);
      op(PTW_OP_BACKUP_ENTRY);
      stat(32'h40, 32'h60);
      $display("test watchdog done");
      setctl(8'h00);
      val = 8'($random(seed));
      arg(2'd0, val);
      op(PTW_OP_WRITE_PRESCALER);
      op(PTW_OP_READ_PRESCALER);
      rd(PTW_ADDR_RESULT, {24'h0, val}, 32'hFF, 2'b00);
      for (int t = 0; t < 3; t++) begin
         val = 8'($random(seed));
         arg(2'(t), val);
         op(PTW_OP_WRITE_TIMER);
         op(PTW_OP_READ_TIMER);
         rd(PTW_ADDR_RESULT, {24'h0, val}, 32'hFF, 2'b00);
      end
      $display("test load and read done");
      arg(2'd0, 8'h00);
      op(PTW_OP_WRITE_PRESCALER);
      arg(2'd1, 8'h02);
      op(PTW_OP_WRITE_TIMER);
      op(PTW_OP_WRITE_RELOAD);
      setctl(8'h0B);
      for (int i = 0; i < 3000 && ifc.uflow[1] !== 1'b1; i++) @(posedge clk_sys);
      setctl(8'h00);
      stat(32'h02, 32'h07);
      $display("test timer 2 done");
      for (int e = 0; e < 2; e++) begin
         counter_pin_zero <= e[0];
         setctl(8'h20 | (8'(e) << 6));
         arg(2'd0, 8'h01);
         op(PTW_OP_WRITE_TIMER);
         setctl(8'h24 | (8'(e) << 6));
         repeat (8) begin
            repeat (4) @(posedge clk_sys);
            counter_pin_zero <= ~counter_pin_zero;
         end
         setctl(8'h00);
         stat(32'h01, 32'h01);
         op(PTW_OP_SKIP_FIRST);
         stat(32'h00, 32'h01);
      end
      $display("test pin count done");
      arg(2'd2, 8'h08);
      op(PTW_OP_LOAD_THIRD_BOTH);
      arg(2'd2, 8'h04);
      op(PTW_OP_WRITE_THIRD_HIGH);
      setctl(8'h93);
      repeat (600) @(posedge clk_sys);
      port_c_latch <= 1'b0;
      @(negedge clk_sys);
      while (counter_pin_one !== 1'b0) @(negedge clk_sys);
      while (counter_pin_one !== 1'b1) @(negedge clk_sys);
      cnt = 0;
      while (counter_pin_one === 1'b1) begin
         cnt++;
         @(negedge clk_sys);
      end
      chk("pwm high cycles", 32'h5, cnt, 32'hFF);
      cnt = 0;
      while (counter_pin_one === 1'b0) begin
         cnt++;
         @(negedge clk_sys);
      end
      chk("pwm low cycles", 32'h9, cnt, 32'hFF);
      repeat (600) @(posedge clk_sys);
      setctl(8'h00);
      stat(32'h04, 32'h04);
      $display("test pwm done");
      op(PTW_OP_DISABLE_WATCHDOG);
      op(PTW_OP_WATCHDOG_RESTART);
      stat(32'h00, 32'h40);
      $display("test watchdog disable done");
      end_sim();
   end
   initial begin
      #900000;
      failures++;
      end_sim();
   end
endmodule : tb_top
`default_nettype wire

/* verilog/ptw_controller.sv */
/*
 CPU-side controller: AXI4-Lite slave that issues timer operations.
 Assumes software keeps the stop-before-access orderings.
*/
`timescale 1ns/1ns
`default_nettype none
module ptw_controller (
   input wire logic clk_sys,
   input wire logic rst_b,
   ptw_if.ctl_end bus,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import ptw_pkg::*;
   logic [31:0] arg_reg, arg_next;
   ptw_op_type op_reg, op_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic wr_go;

   assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
   always_comb begin
      arg_next = arg_reg;
      op_next = PTW_OP_NONE;
      bvalid_next = bvalid_reg && !s_axi_bready;
      bresp_next = bresp_reg;
      if (wr_go) begin
         bvalid_next = 1'b1;
         bresp_next = 2'b00;
         if (s_axi_awaddr == PTW_ADDR_CMD) begin
            // Op code issued for exactly one cycle; stop-before-access is software's duty
            op_next = ptw_op_type'(s_axi_wdata[3:0]);
         end else if (s_axi_awaddr == PTW_ADDR_ARG) begin
            for (int b = 0; b < 4; b++) begin
               if (s_axi_wstrb[b]) begin
                  arg_next[8*b +: 8] = s_axi_wdata[8*b +: 8];
               end
            end
         end else begin
            bresp_next = 2'b10;
         end
      end
      rvalid_next = rvalid_reg && !s_axi_rready;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (s_axi_arvalid && !rvalid_reg) begin
         rvalid_next = 1'b1;
         rresp_next = 2'b00;
         if (s_axi_araddr == PTW_ADDR_ARG) begin
            rdata_next = arg_reg;
         end else if (s_axi_araddr == PTW_ADDR_RESULT) begin
            rdata_next = {24'h000000, bus.rdata};
         end else if (s_axi_araddr == PTW_ADDR_STATUS) begin
            rdata_next = {24'h000000, bus.pwm, bus.wdt_enable, bus.wdt_flag, bus.skip, 1'b0, bus.uflow};
         end else if (s_axi_araddr == PTW_ADDR_CMD) begin
            rdata_next = 32'h00000000;
         end else begin
            rdata_next = 32'h00000000;
            rresp_next = 2'b10;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         arg_reg <= 32'h00000000;
         op_reg <= PTW_OP_NONE;
         bvalid_reg <= 1'b0;
         bresp_reg <= 2'b00;
         rvalid_reg <= 1'b0;
         rresp_reg <= 2'b00;
         rdata_reg <= 32'h00000000;
      end else begin
         arg_reg <= arg_next;
         op_reg <= op_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
      end
   end

   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = s_axi_arvalid && !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign bus.op = op_reg;
   assign bus.sel = arg_reg[17:16];
   assign bus.wdata = arg_reg[7:0];
   // Control bits are software's; irq enable sits in argument bit 8
   assign bus.ctl = {arg_reg[8], arg_reg[31:24]} ^ PTW_CTL_RESET;
endmodule : ptw_controller
`default_nettype wire

/* verilog/ptw_device.sv */
/*
 Prescaler, three down-counting timers with reloads, PWM on timer 3, watchdog.
 Assumes one op per cycle from the controller and an asynchronous counter pin input.
*/
// Chosen in the package and controller: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module ptw_device (
   input wire logic clk_sys,
   input wire logic rst_b,
   ptw_if.dev bus,
   input wire logic counter_pin_zero,
   input wire logic port_c_latch,
   output logic counter_pin_one,
   output logic system_reset_req
);
   import ptw_pkg::*;
   logic [PTW_DATA_W-1:0] presc_reg, presc_next;
   logic [PTW_DATA_W-1:0] cnt_reg [3], cnt_next [3];
   logic [PTW_DATA_W-1:0] rld_reg [3], rld_next [3];
   logic [PTW_DATA_W-1:0] rld3h_reg, rld3h_next;
   logic [PTW_DATA_W-1:0] rdata_reg, rdata_next;
   logic [7:0] div_reg, div_next;
   logic [2:0] flag_reg, flag_next;
   logic pwm_reg, pwm_next;
   logic pwm_high_reg, pwm_high_next;
   logic pin_s1_reg, pin_s2_reg, pin_s3_reg;
   logic [PTW_WDT_W-1:0] wdt_reg, wdt_next;
   logic wdt_en_reg, wdt_en_next, wdt_flag_reg, wdt_flag_next;
   logic dis_arm_reg, dis_arm_next;
   logic skip_reg, skip_next;
   logic rst_req_reg, rst_req_next;
   logic instruction_clock, presc_tick, pin_edge, src [3], edge_hit [3], uf [3];
   logic [2:0] run;

   assign instruction_clock = (div_reg == 8'h00);
   // Prescaler output tick; its source is the instruction clock when bit clear
   assign presc_tick = bus.ctl[PTW_CTL_PRESC_RUN] && (presc_reg == '0) &&
      (bus.ctl[PTW_CTL_PRESC_SRC] ? 1'b1 : instruction_clock);
   assign run = {bus.ctl[PTW_CTL_T3_RUN], bus.ctl[PTW_CTL_T2_RUN], bus.ctl[PTW_CTL_T1_RUN]};
   always_comb begin
      // Timer 1 may follow the synchronised pin edge selected by software
      pin_edge = (pin_s2_reg ^ bus.ctl[PTW_CTL_T1_EDGE]) && !(pin_s3_reg ^ bus.ctl[PTW_CTL_T1_EDGE]);
      src[0] = bus.ctl[PTW_CTL_T1_PIN] ? pin_edge : presc_tick;
      src[1] = presc_tick;
      src[2] = presc_tick;
   end

   generate
      for (genvar i = 0; i < 3; i++) begin : g_tmr
         // Each source pulse is one edge; the first one after start is the first count
         assign edge_hit[i] = run[i] && src[i];
         assign uf[i] = edge_hit[i] && (cnt_reg[i] == '0);
         always_comb begin
            cnt_next[i] = cnt_reg[i];
            rld_next[i] = rld_reg[i];
            if (uf[i]) begin
               // Entering the PWM high phase loads the high reload
               cnt_next[i] = (i == 2 && bus.ctl[PTW_CTL_PWM_EN] && !pwm_high_reg) ? rld3h_reg : rld_reg[i];
            end else if (edge_hit[i]) begin
               cnt_next[i] = cnt_reg[i] - 8'h01;
            end
            if (bus.op == PTW_OP_WRITE_TIMER && bus.sel == 2'(i)) begin
               cnt_next[i] = bus.wdata;
            end
            if (bus.op == PTW_OP_LOAD_THIRD_BOTH && i == 2) begin
               cnt_next[i] = bus.wdata;
               rld_next[i] = bus.wdata;
            end
            if (bus.op == PTW_OP_WRITE_RELOAD && bus.sel == 2'(i)) begin
               rld_next[i] = bus.wdata;
            end
         end
         always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
               cnt_reg[i] <= 8'hFF;
               rld_reg[i] <= 8'hFF;
            end else begin
               cnt_reg[i] <= cnt_next[i];
               rld_reg[i] <= rld_next[i];
            end
         end
      end
   endgenerate

   always_comb begin
      div_next = instruction_clock ? PTW_INSTRUCTION_CLOCK_DIV : div_reg - 8'h01;
      presc_next = presc_reg;
      if (bus.ctl[PTW_CTL_PRESC_RUN] && (bus.ctl[PTW_CTL_PRESC_SRC] || instruction_clock)) begin
         presc_next = (presc_reg == '0) ? 8'h00 : presc_reg - 8'h01;
      end
      if (bus.op == PTW_OP_WRITE_PRESCALER) begin
         presc_next = bus.wdata;
      end
      rld3h_next = rld3h_reg;
      if (bus.op == PTW_OP_WRITE_THIRD_HIGH) begin
         rld3h_next = bus.wdata;
      end
      // PWM toggles phase on each timer 3 underflow; high phase uses the high reload
      pwm_next = pwm_reg;
      pwm_high_next = pwm_high_reg;
      if (!bus.ctl[PTW_CTL_PWM_EN]) begin
         pwm_next = 1'b0;
         pwm_high_next = 1'b0;
      end else if (uf[2]) begin
         pwm_next = !pwm_reg;
         pwm_high_next = !pwm_high_reg;
      end
      // Timer select 3 keeps the previous result
      rdata_next = rdata_reg;
      if (bus.op == PTW_OP_READ_PRESCALER) begin
         rdata_next = presc_reg;
      end else if (bus.op == PTW_OP_READ_TIMER && bus.sel != 2'd3) begin
         rdata_next = cnt_reg[bus.sel];
      end
      // Hardware set wins over the skip clear
      flag_next = flag_reg | {uf[2], uf[1], uf[0]};
      skip_next = 1'b0;
      if (bus.op == PTW_OP_SKIP_FIRST) begin
         skip_next = !bus.ctl[PTW_CTL_IRQ_EN] && flag_reg[0];
         if (!bus.ctl[PTW_CTL_IRQ_EN] && !uf[0]) begin
            flag_next[0] = 1'b0;
         end
      end
      if (bus.ctl[PTW_CTL_IRQ_EN] && !uf[0]) begin
         flag_next[0] = 1'b0;
      end
      // Watchdog
      wdt_en_next = wdt_en_reg;
      wdt_flag_next = wdt_flag_reg;
      rst_req_next = 1'b0;
      // A disable stays armed until the next op; only a restart as that op stops the watchdog
      dis_arm_next = dis_arm_reg;
      if (bus.op == PTW_OP_DISABLE_WATCHDOG) begin
         dis_arm_next = 1'b1;
      end else if (bus.op != PTW_OP_NONE) begin
         dis_arm_next = 1'b0;
      end
      wdt_next = wdt_reg;
      if (wdt_en_reg) begin
         wdt_next = wdt_reg - 16'h0001;
         if (wdt_reg == '0) begin
            rst_req_next = wdt_flag_reg;
            wdt_flag_next = 1'b1;
         end
      end
      // Restart reloads the counter; an expiry in the same cycle keeps its flag
      if (bus.op == PTW_OP_WATCHDOG_RESTART) begin
         wdt_next = PTW_WDT_RESET;
         if (!(wdt_en_reg && wdt_reg == '0)) begin
            wdt_flag_next = 1'b0;
         end
         if (dis_arm_reg) begin
            wdt_en_next = 1'b0;
         end
      end
      // Back-up entry initialises the flag and the counter
      if (bus.op == PTW_OP_BACKUP_ENTRY) begin
         wdt_flag_next = 1'b0;
         wdt_next = PTW_WDT_RESET;
      end
   end

   always_ff @(posedge clk_sys) begin
      pin_s1_reg <= counter_pin_zero;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      if (!rst_b) begin
         div_reg <= PTW_INSTRUCTION_CLOCK_DIV;
         presc_reg <= 8'h00;
         rld3h_reg <= 8'h01;
         pwm_reg <= 1'b0;
         pwm_high_reg <= 1'b0;
         rdata_reg <= 8'h00;
         flag_reg <= 3'h0;
         skip_reg <= 1'b0;
         wdt_reg <= PTW_WDT_RESET;
         wdt_en_reg <= 1'b1;
         wdt_flag_reg <= 1'b0;
         dis_arm_reg <= 1'b0;
         rst_req_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         presc_reg <= presc_next;
         rld3h_reg <= rld3h_next;
         pwm_reg <= pwm_next;
         pwm_high_reg <= pwm_high_next;
         rdata_reg <= rdata_next;
         flag_reg <= flag_next;
         skip_reg <= skip_next;
         wdt_reg <= wdt_next;
         wdt_en_reg <= wdt_en_next;
         wdt_flag_reg <= wdt_flag_next;
         dis_arm_reg <= dis_arm_next;
         rst_req_reg <= rst_req_next;
      end
   end

   assign bus.rdata = rdata_reg;
   assign bus.skip = skip_reg;
   assign bus.uflow = flag_reg;
   assign bus.wdt_flag = wdt_flag_reg;
   assign bus.wdt_enable = wdt_en_reg;
   assign bus.pwm = pwm_reg;
   // Pin shows PWM only while the port latch is low
   assign counter_pin_one = pwm_reg & !port_c_latch;
   assign system_reset_req = rst_req_reg;
endmodule : ptw_device
`default_nettype wire
